// ==== hw/volume_ramp_defs.vh ====
`ifndef VOLUME_RAMP_DEFS_VH
`define VOLUME_RAMP_DEFS_VH

// ****************************************
// register indices, byte address is four times the index
// ****************************************
`define IDX_TARGET_VOLUME      8'h4c
`define IDX_RAMP_NORMAL        8'h4e
`define IDX_RAMP_EMERGENCY     8'h4f
`define IDX_AUTO_MUTE_ENABLE   8'h50
`define IDX_AUTO_MUTE_TIME     8'h51
`define IDX_RAMP_STATUS        8'h7f

// ****************************************
// reset values
// ****************************************
`define RST_TARGET_VOLUME      8'h30
`define RST_RAMP_NORMAL        8'h33
`define RST_RAMP_EMERGENCY     8'h30
`define RST_AUTO_MUTE_ENABLE   8'h07
`define RST_AUTO_MUTE_TIME     8'h00

// ****************************************
// field positions
// ****************************************
`define F_DOWN_RATE_HI         7
`define F_DOWN_RATE_LO         6
`define F_DOWN_STEP_HI         5
`define F_DOWN_STEP_LO         4
`define F_UP_RATE_HI           3
`define F_UP_RATE_LO           2
`define F_UP_STEP_HI           1
`define F_UP_STEP_LO           0
`define F_MUTE_LINK            2
`define F_MUTE_EN_RIGHT        1
`define F_MUTE_EN_LEFT         0
`define F_TIME_LEFT_HI         6
`define F_TIME_LEFT_LO         4
`define F_TIME_RIGHT_HI        2
`define F_TIME_RIGHT_LO        0

// ****************************************
// codes
// ****************************************
`define RATE_EVERY_1           2'h0
`define RATE_EVERY_2           2'h1
`define RATE_EVERY_4           2'h2
`define RATE_INSTANT           2'h3
`define STEP_4_DB              2'h0
`define STEP_2_DB              2'h1
`define STEP_1_DB              2'h2
`define STEP_HALF_DB           2'h3
`define VOL_CODE_MUTE          8'hff
`define SAMPLE_WIDTH           24

// ****************************************
// zero-run lengths in samples at 96 kHz
// ****************************************
`define ZERO_RUN_0             19'h00450
`define ZERO_RUN_1             19'h013e0
`define ZERO_RUN_2             19'h027f0
`define ZERO_RUN_3             19'h063f0
`define ZERO_RUN_4             19'h0c8a0
`define ZERO_RUN_5             19'h18f60
`define ZERO_RUN_6             19'h3e760
`define ZERO_RUN_7             19'h7ced0

`endif

// ==== hw/volume_ramp_auto_mute_ctrl.v ====
`timescale 1ns/1ns
`include "volume_ramp_defs.vh"

module volume_ramp_auto_mute_ctrl #(
    parameter ZERO_RUN_SHIFT = 0
)(
    input  wire                      mclk,
    input  wire                      rst,
    input  wire                      wb_cyc,
    input  wire                      wb_stb,
    input  wire                      wb_we,
    input  wire [9:0]                wb_adr,
    input  wire [3:0]                wb_sel,
    input  wire [31:0]               wb_wdata,
    output reg  [31:0]               wb_rdata,
    output reg                       wb_ack,
    input  wire                      sample_strobe,
    input  wire [`SAMPLE_WIDTH-1:0]  sample_left,
    input  wire [`SAMPLE_WIDTH-1:0]  sample_right,
    input  wire                      emergency_pin,
    output wire [7:0]                applied_volume_left,
    output wire [7:0]                applied_volume_right,
    output wire                      auto_mute_left,
    output wire                      auto_mute_right
);

    // ****************************************
    // step and rate decode
    // ****************************************
    function [7:0] step_codes;
        input [1:0] code;
        begin
            case (code)
                `STEP_4_DB:    step_codes = 8'h08;
                `STEP_2_DB:    step_codes = 8'h04;
                `STEP_1_DB:    step_codes = 8'h02;
                `STEP_HALF_DB: step_codes = 8'h01;
                default:       step_codes = 8'h01;
            endcase
        end
    endfunction

    function [1:0] rate_last;
        input [1:0] code;
        begin
            case (code)
                `RATE_EVERY_1: rate_last = 2'h0;
                `RATE_EVERY_2: rate_last = 2'h1;
                `RATE_EVERY_4: rate_last = 2'h3;
                default:       rate_last = 2'h0;
            endcase
        end
    endfunction

    function [18:0] zero_run_len;
        input [2:0] code;
        begin
            case (code)
                3'h0:    zero_run_len = `ZERO_RUN_0;
                3'h1:    zero_run_len = `ZERO_RUN_1;
                3'h2:    zero_run_len = `ZERO_RUN_2;
                3'h3:    zero_run_len = `ZERO_RUN_3;
                3'h4:    zero_run_len = `ZERO_RUN_4;
                3'h5:    zero_run_len = `ZERO_RUN_5;
                3'h6:    zero_run_len = `ZERO_RUN_6;
                3'h7:    zero_run_len = `ZERO_RUN_7;
                default: zero_run_len = `ZERO_RUN_0;
            endcase
        end
    endfunction

    // ****************************************
    // registers
    // ****************************************
    reg  [7:0]  target_volume_code;
    reg  [7:0]  volume_ramp_normal_ctrl;
    reg  [7:0]  volume_ramp_emergency_ctrl;
    reg  [7:0]  auto_mute_enable_ctrl;
    reg  [7:0]  auto_mute_time_ctrl;
    wire [7:0]  applied [0:1];
    reg  [1:0]  auto_mute;
    reg         emergency_s1;
    reg         emergency_s2;
    reg         emergency_s3;
    reg         emergency_active;
    wire [1:0]  qualified;
    wire [7:0]  index;
    wire        bus_req;
    wire        bus_write;
    wire        write_target;
    wire        write_normal;
    wire        write_emergency;
    wire        write_enable;
    wire        write_time;
    wire [31:0] status_word;
    reg  [31:0] next_rdata;
    wire [1:0]  normal_down_update_rate;
    wire [1:0]  normal_down_step_size;
    wire [1:0]  up_update_rate;
    wire [1:0]  up_step_size;
    wire [1:0]  emergency_update_rate;
    wire [1:0]  emergency_step_size;
    wire        mute_link;
    wire [2:0]  zero_time_left;
    wire [2:0]  zero_time_right;

    assign index     = wb_adr[9:2];
    assign bus_req   = wb_cyc & wb_stb & ~wb_ack;
    assign bus_write = bus_req & wb_we & wb_sel[0];

    // ****************************************
    // write decode
    // ****************************************
    assign write_target    = bus_write & (index == `IDX_TARGET_VOLUME);
    assign write_normal    = bus_write & (index == `IDX_RAMP_NORMAL);
    assign write_emergency = bus_write & (index == `IDX_RAMP_EMERGENCY);
    assign write_enable    = bus_write & (index == `IDX_AUTO_MUTE_ENABLE);
    assign write_time      = bus_write & (index == `IDX_AUTO_MUTE_TIME);

    // ****************************************
    // field decode
    // ****************************************
    assign normal_down_update_rate = volume_ramp_normal_ctrl[`F_DOWN_RATE_HI:`F_DOWN_RATE_LO];
    assign normal_down_step_size   = volume_ramp_normal_ctrl[`F_DOWN_STEP_HI:`F_DOWN_STEP_LO];
    assign up_update_rate          = volume_ramp_normal_ctrl[`F_UP_RATE_HI:`F_UP_RATE_LO];
    assign up_step_size            = volume_ramp_normal_ctrl[`F_UP_STEP_HI:`F_UP_STEP_LO];
    assign emergency_update_rate   = volume_ramp_emergency_ctrl[`F_DOWN_RATE_HI:`F_DOWN_RATE_LO];
    assign emergency_step_size     = volume_ramp_emergency_ctrl[`F_DOWN_STEP_HI:`F_DOWN_STEP_LO];
    assign mute_link               = auto_mute_enable_ctrl[`F_MUTE_LINK];
    assign zero_time_left          = auto_mute_time_ctrl[`F_TIME_LEFT_HI:`F_TIME_LEFT_LO];
    assign zero_time_right         = auto_mute_time_ctrl[`F_TIME_RIGHT_HI:`F_TIME_RIGHT_LO];
    assign status_word             = {13'h0000, emergency_active, auto_mute, applied[1], applied[0]};

    // ****************************************
    // wishbone slave
    // ****************************************
    always @*
    begin
        next_rdata = 32'h00000000;
        case (index)
            `IDX_TARGET_VOLUME:    next_rdata = {24'h000000, target_volume_code};
            `IDX_RAMP_NORMAL:      next_rdata = {24'h000000, volume_ramp_normal_ctrl};
            `IDX_RAMP_EMERGENCY:   next_rdata = {24'h000000, volume_ramp_emergency_ctrl};
            `IDX_AUTO_MUTE_ENABLE: next_rdata = {24'h000000, auto_mute_enable_ctrl};
            `IDX_AUTO_MUTE_TIME:   next_rdata = {24'h000000, auto_mute_time_ctrl};
            `IDX_RAMP_STATUS:      next_rdata = status_word;
            default:               next_rdata = 32'h00000000;
        endcase
    end

    always @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            wb_ack                     <= 1'b0;
            wb_rdata                   <= 32'h00000000;
            target_volume_code         <= `RST_TARGET_VOLUME;
            volume_ramp_normal_ctrl    <= `RST_RAMP_NORMAL;
            volume_ramp_emergency_ctrl <= `RST_RAMP_EMERGENCY;
            auto_mute_enable_ctrl      <= `RST_AUTO_MUTE_ENABLE;
            auto_mute_time_ctrl        <= `RST_AUTO_MUTE_TIME;
        end
        else
        begin
            wb_ack <= bus_req;
            if (bus_req & ~wb_we)
                wb_rdata <= next_rdata;
            if (write_target)
                target_volume_code         <= wb_wdata[7:0];
            if (write_normal)
                volume_ramp_normal_ctrl    <= wb_wdata[7:0];
            if (write_emergency)
                volume_ramp_emergency_ctrl <= wb_wdata[7:0];
            if (write_enable)
                auto_mute_enable_ctrl      <= wb_wdata[7:0];
            if (write_time)
                auto_mute_time_ctrl        <= wb_wdata[7:0];
        end
    end

    // ****************************************
    // emergency pin synchroniser
    // ****************************************
    always @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            emergency_s1     <= 1'b0;
            emergency_s2     <= 1'b0;
            emergency_s3     <= 1'b0;
            emergency_active <= 1'b0;
        end
        else
        begin
            emergency_s1 <= emergency_pin;
            emergency_s2 <= emergency_s1;
            emergency_s3 <= emergency_s2;
            if (emergency_s2 == emergency_s3)
                emergency_active <= emergency_s3;
        end
    end

    // ****************************************
    // auto mute decision
    // ****************************************
    always @(posedge mclk or posedge rst)
    begin
        if (rst)
            auto_mute <= 2'b00;
        else if (mute_link)
            auto_mute <= {2{qualified[0] & qualified[1]}};
        else
            auto_mute <= qualified;
    end

    // ****************************************
    // outputs
    // ****************************************
    assign applied_volume_left  = applied[0];
    assign applied_volume_right = applied[1];
    assign auto_mute_left       = auto_mute[0];
    assign auto_mute_right      = auto_mute[1];

    // ****************************************
    // per-channel zero run and volume ramp
    // ****************************************
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch = ch + 1)
        begin : chan
            reg  [18:0] zero_run;
            reg  [7:0]  level;
            reg  [1:0]  rate_count;
            reg  [7:0]  next_applied;
            reg  [1:0]  next_rate_count;
            reg  [1:0]  sel_rate;
            reg  [7:0]  sel_step;
            reg  [8:0]  down_sum;
            wire [`SAMPLE_WIDTH-1:0] sample;
            wire [18:0] run_len;
            wire        enable;
            wire [7:0]  goal;

            assign sample  = (ch == 0) ? sample_left : sample_right;
            assign run_len = zero_run_len((ch == 0) ? zero_time_left : zero_time_right) >> ZERO_RUN_SHIFT;
            assign enable  = (ch == 0) ? auto_mute_enable_ctrl[`F_MUTE_EN_LEFT]
                                       : auto_mute_enable_ctrl[`F_MUTE_EN_RIGHT];
            assign qualified[ch] = enable & (zero_run >= run_len);
            assign goal = (emergency_active | auto_mute[ch]) ? `VOL_CODE_MUTE : target_volume_code;
            assign applied[ch] = level;

            always @(posedge mclk or posedge rst)
            begin
                if (rst)
                    zero_run <= 19'h00000;
                else if (sample_strobe)
                begin
                    if (sample != {`SAMPLE_WIDTH{1'b0}})
                        zero_run <= 19'h00000;
                    else if (zero_run < run_len)
                        zero_run <= zero_run + 19'h00001;
                end
            end

            // ****************************************
            // ramp step
            // ****************************************
            always @*
            begin
                next_applied    = applied[ch];
                next_rate_count = rate_count;
                down_sum        = {1'b0, applied[ch]};
                if (applied[ch] < goal)
                begin
                    sel_rate = emergency_active ? emergency_update_rate : normal_down_update_rate;
                    sel_step = emergency_active ? step_codes(emergency_step_size)
                                                : step_codes(normal_down_step_size);
                end
                else
                begin
                    sel_rate = up_update_rate;
                    sel_step = step_codes(up_step_size);
                end
                if (sample_strobe)
                begin
                    if (applied[ch] == goal)
                        next_rate_count = 2'h0;
                    else if (sel_rate == `RATE_INSTANT)
                    begin
                        next_applied    = goal;
                        next_rate_count = 2'h0;
                    end
                    else if (rate_count >= rate_last(sel_rate))
                    begin
                        next_rate_count = 2'h0;
                        if (applied[ch] < goal)
                        begin
                            down_sum = {1'b0, applied[ch]} + {1'b0, sel_step};
                            if (down_sum >= {1'b0, goal})
                                next_applied = goal;
                            else
                                next_applied = down_sum[7:0];
                        end
                        else if ((applied[ch] - goal) <= sel_step)
                            next_applied = goal;
                        else
                            next_applied = applied[ch] - sel_step;
                    end
                    else
                        next_rate_count = rate_count + 2'h1;
                end
            end

            always @(posedge mclk or posedge rst)
            begin
                if (rst)
                begin
                    level      <= `RST_TARGET_VOLUME;
                    rate_count <= 2'h0;
                end
                else
                begin
                    level      <= next_applied;
                    rate_count <= next_rate_count;
                end
            end
        end
    endgenerate

endmodule

// ==== dv/volume_ramp_auto_mute_ctrl_chk.sv ====
`timescale 1ns/1ns
module volume_ramp_chk (
    input wire        mclk,
    input wire        rst,
    input wire        wb_cyc,
    input wire        wb_stb,
    input wire        wb_we,
    input wire [31:0] wb_rdata,
    input wire        wb_ack,
    input wire        sample_strobe,
    input wire        emergency_pin,
    input wire [7:0]  applied_volume_left,
    input wire [7:0]  applied_volume_right,
    input wire        auto_mute_left
);
    wire [7:0] vol_l = applied_volume_left;
    wire [7:0] vol_r = applied_volume_right;
    // ****
    // bus and volume checks
    // ****
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    a_ack_follows_req: assert property (wb_cyc && wb_stb && !wb_ack |=> wb_ack)
        else $error("no ack after request");
    a_ack_one_pulse: assert property (wb_ack |=> !wb_ack)
        else $error("ack held too long");
    a_ack_needs_req: assert property (!(wb_cyc && wb_stb) |=> !wb_ack)
        else $error("ack without request");
    a_rdata_on_read: assert property ($changed(wb_rdata) |-> $past(wb_cyc && wb_stb && !wb_we && !wb_ack))
        else $error("read data moved without read");
    a_left_on_strobe: assert property (!sample_strobe |=> $stable(vol_l))
        else $error("left volume moved without strobe");
    a_right_on_strobe: assert property (!sample_strobe |=> $stable(vol_r))
        else $error("right volume moved without strobe");
    a_mute_left_down: assert property ($past(auto_mute_left) && $changed(vol_l) |-> vol_l > $past(vol_l))
        else $error("muted left volume rose");
    a_emerg_right_down: assert property (emergency_pin [*6] ##1 $changed(vol_r) |-> vol_r > $past(vol_r))
        else $error("emergency right volume rose");
endmodule

// ==== dv/tb_top.sv ====
`timescale 1ns/1ns
`include "volume_ramp_defs.vh"
`define CHK(a,e) begin checks_done++; if ((a)!==(e)) begin miscompares++; $display("FAIL %0t got %h",$time,a); end end
module tb_top;
    reg         mclk, rst, wb_cyc, wb_stb, wb_we, sample_strobe, emergency_pin;
    reg  [9:0]  wb_adr;
    reg  [3:0]  wb_sel;
    reg  [31:0] wb_wdata, rdv;
    reg  [23:0] sample_left, sample_right;
    reg  [7:0]  cur;
    wire [31:0] wb_rdata;
    wire        wb_ack, auto_mute_left, auto_mute_right;
    wire [7:0]  applied_volume_left, applied_volume_right;
    integer     miscompares, checks_done, i;
    volume_ramp_auto_mute_ctrl #(.ZERO_RUN_SHIFT(8)) u_volume_ramp_auto_mute_ctrl (
        .mclk(mclk), .rst(rst), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr),
        .wb_sel(wb_sel), .wb_wdata(wb_wdata), .wb_rdata(wb_rdata), .wb_ack(wb_ack),
        .sample_strobe(sample_strobe), .sample_left(sample_left), .sample_right(sample_right),
        .emergency_pin(emergency_pin), .applied_volume_left(applied_volume_left),
        .applied_volume_right(applied_volume_right), .auto_mute_left(auto_mute_left),
        .auto_mute_right(auto_mute_right));
    // ****
    // clock and tasks
    // ****
    initial
    begin
        mclk = 1'h0;
        forever #5 mclk = ~mclk;
    end
    task test_done;
        begin
            $display("checks %0d mismatches %0d", checks_done, miscompares);
            if (miscompares == 0 && checks_done > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    task wb(input w, input [7:0] idx, input [7:0] d);
        integer n;
        begin
            wb_cyc <= 1'h1;
            wb_stb <= 1'h1;
            wb_we <= w;
            wb_adr <= {idx, 2'h0};
            wb_wdata <= {24'h0, d};
            n = 0;
            @(posedge mclk);
            while (wb_ack !== 1'h1 && n < 50)
            begin
                @(posedge mclk);
                n = n + 1;
            end
            `CHK(wb_ack, 1'h1)
            rdv = wb_rdata;
            wb_cyc <= 1'h0;
            wb_stb <= 1'h0;
            @(posedge mclk);
        end
    endtask
    task rchk(input [7:0] idx, input [31:0] e);
        begin
            wb(1'h0, idx, 8'h0);
            `CHK(rdv, e)
        end
    endtask
    task st(input integer n);
        repeat (n)
        begin
            sample_strobe <= 1'h1;
            @(posedge mclk);
            sample_strobe <= 1'h0;
            @(posedge mclk);
        end
    endtask
    task mchk(input l, input r);
        begin
            repeat (2) @(posedge mclk);
            `CHK({auto_mute_left, auto_mute_right}, {l, r})
        end
    endtask
    task ramp(input [7:0] idx, input [7:0] ctl, input [7:0] tgt, input integer n, input [7:0] e);
        begin
            wb(1'h1, idx, ctl);
            wb(1'h1, `IDX_TARGET_VOLUME, tgt);
            st(n - 1);
            `CHK(applied_volume_left, cur)
            st(1);
            `CHK(applied_volume_left, e)
            `CHK(applied_volume_right, e)
            wb(1'h1, `IDX_TARGET_VOLUME, e);
            cur = e;
        end
    endtask
    // ****
    // tests
    // ****
    initial
    begin
        miscompares = 0;
        checks_done = 0;
        cur = 8'h30;
        rst = 1'h1;
        {wb_cyc, wb_stb, wb_we, sample_strobe, emergency_pin} = 5'h0;
        wb_adr = 10'h0;
        wb_sel = 4'hf;
        wb_wdata = 32'h0;
        sample_left = 24'h1;
        sample_right = 24'h1;
        repeat (6) @(posedge mclk);
        rst <= 1'h0;
        @(posedge mclk);
        rchk(`IDX_RAMP_NORMAL, 32'h33);
        rchk(`IDX_RAMP_EMERGENCY, 32'h30);
        rchk(`IDX_AUTO_MUTE_ENABLE, 32'h7);
        rchk(`IDX_TARGET_VOLUME, 32'h30);
        rchk(`IDX_AUTO_MUTE_TIME, 32'h0);
        wb_sel <= 4'he;
        wb(1'h1, `IDX_AUTO_MUTE_TIME, 8'h77);
        wb_sel <= 4'hf;
        rchk(`IDX_AUTO_MUTE_TIME, 32'h0);
        rchk(`IDX_RAMP_STATUS, 32'h3030);
        rchk(8'h60, 32'h0);
        $display("test reset done");
        for (i = 0; i < 4; i = i + 1)
            ramp(`IDX_RAMP_NORMAL, {2'h0, i[1:0], 4'h3}, cur + 8'h10, 1, cur + (8'h8 >> i));
        for (i = 0; i < 4; i = i + 1)
            ramp(`IDX_RAMP_NORMAL, {6'h0, i[1:0]}, cur - 8'h10, 1, cur - (8'h8 >> i));
        for (i = 1; i < 3; i = i + 1)
            ramp(`IDX_RAMP_NORMAL, {i[1:0], 6'h3}, cur + 8'h20, 1 << i, cur + 8'h8);
        ramp(`IDX_RAMP_NORMAL, 8'hc3, 8'h80, 1, 8'h80);
        for (i = 1; i < 3; i = i + 1)
            ramp(`IDX_RAMP_NORMAL, {4'h0, i[1:0], 2'h0}, cur - 8'h20, 1 << i, cur - 8'h8);
        ramp(`IDX_RAMP_NORMAL, 8'h0c, 8'h30, 1, 8'h30);
        ramp(`IDX_RAMP_NORMAL, 8'h00, 8'h33, 1, 8'h33);
        ramp(`IDX_RAMP_NORMAL, 8'h00, 8'h30, 1, 8'h30);
        $display("test ramp done");
        emergency_pin <= 1'h1;
        repeat (6) @(posedge mclk);
        for (i = 1; i < 3; i = i + 1)
            ramp(`IDX_RAMP_EMERGENCY, {i[1:0], 6'h0}, 8'h30, 1 << i, cur + 8'h8);
        for (i = 0; i < 4; i = i + 1)
            ramp(`IDX_RAMP_EMERGENCY, {2'h0, i[1:0], 4'h0}, 8'h30, 1, cur + (8'h8 >> i));
        ramp(`IDX_RAMP_EMERGENCY, 8'hc0, 8'h30, 1, 8'hff);
        rchk(`IDX_RAMP_STATUS, 32'h4ffff);
        emergency_pin <= 1'h0;
        repeat (6) @(posedge mclk);
        ramp(`IDX_RAMP_NORMAL, 8'h0c, 8'h30, 1, 8'h30);
        $display("test emergency done");
        wb(1'h1, `IDX_AUTO_MUTE_ENABLE, 8'h01);
        sample_left <= 24'h0;
        sample_right <= 24'h0;
        st(3);
        mchk(1'h0, 1'h0);
        st(1);
        mchk(1'h1, 1'h0);
        wb(1'h1, `IDX_AUTO_MUTE_ENABLE, 8'h03);
        mchk(1'h1, 1'h1);
        wb(1'h1, `IDX_AUTO_MUTE_ENABLE, 8'h07);
        sample_right <= 24'h1;
        st(1);
        mchk(1'h0, 1'h0);
        sample_right <= 24'h0;
        st(4);
        mchk(1'h1, 1'h1);
        wb(1'h1, `IDX_AUTO_MUTE_ENABLE, 8'h06);
        mchk(1'h0, 1'h0);
        wb(1'h1, `IDX_AUTO_MUTE_ENABLE, 8'h03);
        wb(1'h1, `IDX_AUTO_MUTE_TIME, 8'h10);
        mchk(1'h0, 1'h1);
        st(14);
        mchk(1'h0, 1'h1);
        st(1);
        mchk(1'h1, 1'h1);
        rchk(`IDX_RAMP_STATUS, 32'h3a830);
        $display("test auto mute done");
        test_done;
    end
    initial
    begin
        repeat (20000) @(posedge mclk);
        `CHK(1'h0, 1'h1)
        test_done;
    end
endmodule
bind volume_ramp_auto_mute_ctrl volume_ramp_chk u_volume_ramp_chk (
    .mclk(mclk), .rst(rst), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we), .wb_rdata(wb_rdata),
    .wb_ack(wb_ack), .sample_strobe(sample_strobe), .emergency_pin(emergency_pin),
    .applied_volume_left(applied_volume_left), .applied_volume_right(applied_volume_right),
    .auto_mute_left(auto_mute_left));
